// ==== design/drive_cmd_pkg.sv ====
// Constants, codes and carrier types of the drive command word decoder
//
// Contract
// - Word 0 bits 1:0 decode none/stop/run/jog; bits 5:4 none/forward/reverse/none.
// - Word 0 bits 7:6 pick one of four accel/decel sets, 00 first.
// - Word 0 bits 11:8 pick master speed (0) or step speed 1 to 15.
// - Accel set and step speed are taken only from word 0 writes with bit 12 one, and held otherwise.
// - Word 1 is the frequency setpoint in hundredths of a hertz.
// - Word 2 bit 0 raises external fault; bit 1 issues a fault reset.
// - Word 2 bit 2 holds the output interrupt (base block) while one.
package drive_cmd_pkg;

   // Word addresses
   localparam logic [1:0] ADDR_CONTROL = 2'h0;
   localparam logic [1:0] ADDR_FREQ = 2'h1;
   localparam logic [1:0] ADDR_FAULT = 2'h2;

   // Control word fields
   localparam int RUN_LSB = 0;
   localparam int DIR_LSB = 4;
   localparam int ACCEL_LSB = 6;
   localparam int STEP_LSB = 8;
   localparam int SEL_EN_BIT = 12;

   // Fault word fields
   localparam int EXT_FAULT_BIT = 0;
   localparam int FAULT_RST_BIT = 1;
   localparam int BASE_BLOCK_BIT = 2;

   // Reset values
   localparam logic [15:0] WORD_RESET = 16'h0000;
   localparam logic [1:0] ACCEL_RESET = 2'h0;
   localparam logic [3:0] STEP_RESET = 4'h0;

   typedef enum logic [1:0] {
      RUN_NONE = 2'b00,
      RUN_STOP = 2'b01,
      RUN_GO = 2'b10,
      RUN_JOG = 2'b11
   } run_code_type;

   typedef enum logic [1:0] {
      DIR_NONE = 2'b00,
      DIR_FWD = 2'b01,
      DIR_REV = 2'b10,
      DIR_NONE2 = 2'b11
   } dir_code_type;

   // Decoded drive commands
   typedef struct packed {
      logic run;
      logic jog;
      logic reverse;
      logic [1:0] accel_set;
      logic [3:0] step_speed;
      logic [15:0] freq_setpoint;
      logic ext_fault;
      logic base_block;
   } drive_cmd_type;

   // Word write request
   typedef struct packed {
      logic valid;
      logic [1:0] addr;
      logic [15:0] data;
   } word_write_type;

endpackage

// ==== design/drive_command_word_decoder.sv ====
// Decoder of the three command words written by the network controller
`timescale 1ns/1ps
`default_nettype none
module drive_command_word_decoder (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire drive_cmd_pkg::word_write_type wr_i,
   input wire logic [1:0] rd_addr_i,
   output logic [15:0] rd_data_o,
   output drive_cmd_pkg::drive_cmd_type cmd_o,
   output logic stop_pulse_o,
   output logic fault_reset_o
);

   logic [15:0] control_word_q;
   logic [15:0] freq_word_q;
   logic [15:0] fault_word_q;
   logic run_q;
   logic jog_q;
   logic reverse_q;
   logic [1:0] accel_q;
   logic [3:0] step_q;
   logic stop_q;
   logic fault_reset_q;
   logic [15:0] rd_data_q;

   logic wr_ctrl;
   logic wr_fault;
   drive_cmd_pkg::run_code_type run_code;
   drive_cmd_pkg::dir_code_type dir_code;

   assign wr_ctrl = wr_i.valid && (wr_i.addr == drive_cmd_pkg::ADDR_CONTROL);
   assign wr_fault = wr_i.valid && (wr_i.addr == drive_cmd_pkg::ADDR_FAULT);
   assign run_code = drive_cmd_pkg::run_code_type'(wr_i.data[drive_cmd_pkg::RUN_LSB +: 2]);
   assign dir_code = drive_cmd_pkg::dir_code_type'(wr_i.data[drive_cmd_pkg::DIR_LSB +: 2]);

   // ----------------------------------------
   // Word storage
   // ----------------------------------------
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         control_word_q <= drive_cmd_pkg::WORD_RESET;
         freq_word_q <= drive_cmd_pkg::WORD_RESET;
         fault_word_q <= drive_cmd_pkg::WORD_RESET;
      end else if (wr_i.valid) begin
         unique case (wr_i.addr)
            drive_cmd_pkg::ADDR_CONTROL: control_word_q <= wr_i.data;
            drive_cmd_pkg::ADDR_FREQ: freq_word_q <= wr_i.data;
            drive_cmd_pkg::ADDR_FAULT: fault_word_q <= wr_i.data;
            default: ;
         endcase
      end
   end

   // ----------------------------------------
   // Run, stop and jog
   // ----------------------------------------
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         run_q <= 1'b0;
         jog_q <= 1'b0;
      end else if (wr_ctrl) begin
         unique case (run_code)
            drive_cmd_pkg::RUN_STOP: begin
               run_q <= 1'b0;
               jog_q <= 1'b0;
            end
            drive_cmd_pkg::RUN_GO: begin
               run_q <= 1'b1;
               jog_q <= 1'b0;
            end
            drive_cmd_pkg::RUN_JOG: begin
               run_q <= 1'b0;
               jog_q <= 1'b1;
            end
            drive_cmd_pkg::RUN_NONE: ;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         stop_q <= 1'b0;
      end else begin
         stop_q <= wr_ctrl && (run_code == drive_cmd_pkg::RUN_STOP);
      end
   end

   // ----------------------------------------
   // Direction
   // ----------------------------------------
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         reverse_q <= 1'b0;
      end else if (wr_ctrl) begin
         unique case (dir_code)
            drive_cmd_pkg::DIR_FWD: reverse_q <= 1'b0;
            drive_cmd_pkg::DIR_REV: reverse_q <= 1'b1;
            drive_cmd_pkg::DIR_NONE, drive_cmd_pkg::DIR_NONE2: ;
         endcase
      end
   end

   // ----------------------------------------
   // Gated accel set and speed source
   // ----------------------------------------
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         accel_q <= drive_cmd_pkg::ACCEL_RESET;
         step_q <= drive_cmd_pkg::STEP_RESET;
      end else if (wr_ctrl && wr_i.data[drive_cmd_pkg::SEL_EN_BIT]) begin
         accel_q <= wr_i.data[drive_cmd_pkg::ACCEL_LSB +: 2];
         step_q <= wr_i.data[drive_cmd_pkg::STEP_LSB +: 4];
      end
   end

   // ----------------------------------------
   // Fault word actions
   // ----------------------------------------
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         fault_reset_q <= 1'b0;
      end else begin
         fault_reset_q <= wr_fault && wr_i.data[drive_cmd_pkg::FAULT_RST_BIT];
      end
   end

   // ----------------------------------------
   // Readback
   // ----------------------------------------
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rd_data_q <= drive_cmd_pkg::WORD_RESET;
      end else begin
         unique case (rd_addr_i)
            drive_cmd_pkg::ADDR_CONTROL: rd_data_q <= control_word_q;
            drive_cmd_pkg::ADDR_FREQ: rd_data_q <= freq_word_q;
            drive_cmd_pkg::ADDR_FAULT: rd_data_q <= fault_word_q;
            default: rd_data_q <= drive_cmd_pkg::WORD_RESET;
         endcase
      end
   end

   assign rd_data_o = rd_data_q;
   assign stop_pulse_o = stop_q;
   assign fault_reset_o = fault_reset_q;
   // One driver for the whole command carrier
   assign cmd_o = '{
      run: run_q,
      jog: jog_q,
      reverse: reverse_q,
      accel_set: accel_q,
      step_speed: step_q,
      freq_setpoint: freq_word_q,
      ext_fault: fault_word_q[drive_cmd_pkg::EXT_FAULT_BIT],
      base_block: fault_word_q[drive_cmd_pkg::BASE_BLOCK_BIT]
   };

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!nrst_i);

   AST_RUN_DECODE: assert property (
      wr_ctrl && run_code == drive_cmd_pkg::RUN_GO |=> cmd_o.run && !cmd_o.jog)
      else $error("run code not applied");
   AST_STOP_DECODE: assert property (
      wr_ctrl && run_code == drive_cmd_pkg::RUN_STOP |=> !cmd_o.run && !cmd_o.jog && stop_pulse_o)
      else $error("stop code not applied");
   AST_JOG_DECODE: assert property (
      wr_ctrl && run_code == drive_cmd_pkg::RUN_JOG |=> cmd_o.jog && !cmd_o.run)
      else $error("jog code not applied");
   AST_DIR_DECODE: assert property (
      wr_ctrl && dir_code == drive_cmd_pkg::DIR_REV |=> cmd_o.reverse)
      else $error("reverse code not applied");
   AST_ACCEL_GATED: assert property (
      wr_ctrl && wr_i.data[drive_cmd_pkg::SEL_EN_BIT]
      |=> cmd_o.accel_set == $past(wr_i.data[drive_cmd_pkg::ACCEL_LSB +: 2]))
      else $error("accel set not taken");
   AST_STEP_GATED: assert property (
      wr_ctrl && wr_i.data[drive_cmd_pkg::SEL_EN_BIT]
      |=> cmd_o.step_speed == $past(wr_i.data[drive_cmd_pkg::STEP_LSB +: 4]))
      else $error("step speed not taken");
   AST_GATE_OFF_HOLDS: assert property (
      wr_ctrl && !wr_i.data[drive_cmd_pkg::SEL_EN_BIT] |=> $stable(cmd_o.step_speed)
      && $stable(cmd_o.accel_set))
      else $error("selection changed without enable");
   AST_FREQ_WORD: assert property (
      wr_i.valid && wr_i.addr == drive_cmd_pkg::ADDR_FREQ
      |=> cmd_o.freq_setpoint == $past(wr_i.data))
      else $error("setpoint not stored");
   AST_FAULT_RESET_PULSE: assert property (
      fault_reset_o |=> !fault_reset_o || $past(wr_fault))
      else $error("fault reset not a pulse");
   AST_FAULT_RESET_FIRE: assert property (
      wr_fault && wr_i.data[drive_cmd_pkg::FAULT_RST_BIT] |=> fault_reset_o)
      else $error("fault reset pulse missing");
   AST_EXT_FAULT: assert property (
      wr_fault |=> cmd_o.ext_fault == $past(wr_i.data[drive_cmd_pkg::EXT_FAULT_BIT]))
      else $error("external fault not applied");
   AST_BASE_BLOCK: assert property (
      wr_fault |=> cmd_o.base_block == $past(wr_i.data[drive_cmd_pkg::BASE_BLOCK_BIT]))
      else $error("base block not applied");
   AST_NO_FUNCTION: assert property (
      wr_ctrl && run_code == drive_cmd_pkg::RUN_NONE |=> $stable(cmd_o.run) && $stable(cmd_o.jog))
      else $error("no-function code changed run state");

   CVR_RUN: cover property (wr_ctrl && run_code == drive_cmd_pkg::RUN_GO);
   CVR_STEP: cover property (wr_ctrl && wr_i.data[drive_cmd_pkg::SEL_EN_BIT]);
   CVR_FAULT_RESET: cover property (fault_reset_o);
   CVR_BASE_BLOCK: cover property (cmd_o.base_block && cmd_o.run);

endmodule
`default_nettype wire

// ==== verification/net_controller_model.sv ====
// Network controller model that writes the drive command words
`timescale 1ns/1ps
`default_nettype none
module net_controller_model (
   input wire logic clk_sys_i,
   output drive_cmd_pkg::word_write_type wr_o
);
   // ----------------------------------------
   // Word writes
   // ----------------------------------------
   initial begin
      wr_o = '0;
   end
   // Reserved bits of words 0 and 2 sent as zero; words 1 and 3 sent unmasked
   task automatic write_word(input logic [1:0] addr, input logic [15:0] data);
      logic [15:0] keep;
      keep = (addr == 2'h0) ? 16'h1ff3 : (addr == 2'h2) ? 16'h0007 : 16'hffff;
      @(posedge clk_sys_i);
      wr_o <= '{valid: 1'b1, addr: addr, data: data & keep};
      @(posedge clk_sys_i);
      wr_o <= '{valid: 1'b0, addr: ~addr, data: ~(data & keep)};
   endtask
   // Bit 12 set only when the selections are wanted
   task automatic write_control(input logic [1:0] run, input logic [1:0] dir,
                                input logic [1:0] acc, input logic [3:0] step,
                                input logic apply);
      write_word(2'h0, {3'h0, apply, step, acc, dir, 2'h0, run});
   endtask
endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
// Self-checking bench of the drive command word decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin comparisons++; if ((got) !== (exp)) begin err_total++; \
   $display("wrong value %s expected %h seen %h", what, exp, got); end end
module testbench;
   // ----------------------------------------
   // Harness
   // ----------------------------------------
   logic clk_sys_i = 1'b0;
   logic nrst_i = 1'b0;
   logic [1:0] rd_addr = 2'h0;
   logic [15:0] rd_data;
   logic stop_pulse;
   logic fault_reset;
   drive_cmd_pkg::word_write_type wr;
   drive_cmd_pkg::drive_cmd_type cmd;
   drive_cmd_pkg::drive_cmd_type held;
   int err_total = 0;
   int comparisons = 0;
   initial begin
      forever #2.5 clk_sys_i = ~clk_sys_i;
   end
   net_controller_model ctl (.clk_sys_i(clk_sys_i), .wr_o(wr));
   drive_command_word_decoder dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .wr_i(wr),
      .rd_addr_i(rd_addr), .rd_data_o(rd_data), .cmd_o(cmd), .stop_pulse_o(stop_pulse),
      .fault_reset_o(fault_reset));
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic read_check(input logic [1:0] a, input logic [15:0] exp);
      @(posedge clk_sys_i);
      rd_addr <= a;
      @(posedge clk_sys_i);
      #1 `CHK("readback", exp, rd_data)
   endtask
   task automatic run_codes;
      ctl.write_control(2'b10, 2'b00, 2'h0, 4'h0, 1'b0);
      #1 `CHK("run jog stop", 3'b100, {cmd.run, cmd.jog, stop_pulse})
      ctl.write_control(2'b11, 2'b00, 2'h0, 4'h0, 1'b0);
      #1 `CHK("run jog", 2'b01, {cmd.run, cmd.jog})
      ctl.write_control(2'b00, 2'b00, 2'h0, 4'h0, 1'b0);
      #1 `CHK("run jog kept", 2'b01, {cmd.run, cmd.jog})
      ctl.write_control(2'b01, 2'b00, 2'h0, 4'h0, 1'b0);
      #1 `CHK("stop", 3'b001, {cmd.run, cmd.jog, stop_pulse})
      @(posedge clk_sys_i);
      #1 `CHK("stop pulse end", 1'b0, stop_pulse)
   endtask
   task automatic directions;
      ctl.write_control(2'b00, 2'b10, 2'h0, 4'h0, 1'b0);
      #1 `CHK("reverse", 1'b1, cmd.reverse)
      ctl.write_control(2'b00, 2'b11, 2'h0, 4'h0, 1'b0);
      #1 `CHK("reverse kept", 1'b1, cmd.reverse)
      ctl.write_control(2'b00, 2'b01, 2'h0, 4'h0, 1'b0);
      #1 `CHK("forward", 1'b0, cmd.reverse)
   endtask
   task automatic selections;
      for (int i = 0; i < 4; i++) begin
         ctl.write_control(2'b00, 2'b00, 2'(i), 4'(i * 5), 1'b1);
         #1 `CHK("accel set", 2'(i), cmd.accel_set)
         `CHK("step speed", 4'(i * 5), cmd.step_speed)
      end
      ctl.write_control(2'b00, 2'b00, 2'h1, 4'h3, 1'b0);
      #1 `CHK("gated off", 6'h3f, {cmd.accel_set, cmd.step_speed})
      read_check(2'h0, 16'h0340);
   endtask
   task automatic freq_and_faults;
      ctl.write_word(2'h1, 16'h1770);
      #1 `CHK("setpoint", 16'h1770, cmd.freq_setpoint)
      read_check(2'h1, 16'h1770);
      ctl.write_word(2'h2, 16'h0007);
      #1 `CHK("fault bits", 3'b111, {cmd.ext_fault, fault_reset, cmd.base_block})
      @(posedge clk_sys_i);
      #1 `CHK("fault held", 3'b101, {cmd.ext_fault, fault_reset, cmd.base_block})
      ctl.write_word(2'h2, 16'h0002);
      #1 `CHK("reset only", 3'b010, {cmd.ext_fault, fault_reset, cmd.base_block})
      read_check(2'h2, 16'h0002);
      held = cmd;
      ctl.write_word(2'h3, 16'hffff);
      #1 `CHK("unmapped write", held, cmd)
      read_check(2'h3, 16'h0000);
   endtask
   task automatic report_and_stop;
      if (err_total == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clk_sys_i);
      #1 `CHK("reset outputs", 30'h0, {cmd, stop_pulse, fault_reset})
      @(posedge clk_sys_i);
      nrst_i <= 1'b1;
      run_codes();
      directions();
      selections();
      freq_and_faults();
      report_and_stop();
   end
   initial begin
      repeat (5000) @(posedge clk_sys_i);
      err_total++;
      report_and_stop();
   end
endmodule
`default_nettype wire
